// >>> hdl/irq_queue_cfg.svh
`ifndef IRQ_QUEUE_CFG_SVH
`define IRQ_QUEUE_CFG_SVH

// Register byte offsets
`define OFS_MASK_LO      8'h00
`define OFS_MASK_HI      8'h04
`define OFS_PRIO_LO      8'h08
`define OFS_PRIO_HI      8'h0C
`define OFS_PEND_LO      8'h10
`define OFS_PEND_HI      8'h14
`define OFS_CLEAR_LO     8'h18
`define OFS_CLEAR_HI     8'h1C
`define OFS_QUEUE_LOW    8'h20
`define OFS_QUEUE_HIGH   8'h24
`define OFS_QUEUE_STAT   8'h28

// Field layout
`define UPPER_BITS       10
`define BIT_DMA_ERR      9
`define BIT_PWR_IQ       8
`define BIT_PWR_5I       7
`define BIT_MEAS_EPOCH   6
`define BIT_ANT_EPOCH    5
`define BIT_PPS          4
`define STAT_LOW_OVF     15
`define STAT_HIGH_OVF    14
`define STAT_LOW_LVL_HI  13
`define STAT_LOW_LVL_LO  7
`define STAT_HIGH_LVL_HI 6
`define STAT_HIGH_LVL_LO 0

// Codes and reset values
`define CODE_W           6
`define CODE_EMPTY       6'h3F
`define CODE_UPPER_BASE  6'h20
`define NUM_SOURCES      42
`define QUEUE_DEPTH      64
`define RESET_ZERO       32'h0000_0000

`endif

// >>> hdl/irq_queue_pkg.sv
package irq_queue_pkg;
	typedef logic [5:0] code_t;
	typedef enum logic {QUEUE_LOW, QUEUE_HIGH} queue_sel_t;
endpackage

// >>> hdl/code_fifo.sv
`timescale 1ns/1ps
`include "irq_queue_cfg.svh"

// ==========================================
// Code queue, first in first out
module code_fifo #(
	parameter int DEPTH = `QUEUE_DEPTH,
	parameter int W     = `CODE_W
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	input  wire logic                       push_i,
	input  wire logic [W-1:0]               data_i,
	input  wire logic                       pop_i,
	output logic      [W-1:0]               head_o,
	output logic                            full_o,
	output logic                            empty_o,
	output logic      [$clog2(DEPTH+1)-1:0] level_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int LW = $clog2(DEPTH+1);

	// Elaboration guard: pointers wrap only on a power-of-two depth
	if (DEPTH < 2 || DEPTH != (1 << AW))
	begin : bad_depth
		$error("code_fifo depth must be a power of two");
	end

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [LW-1:0] level_r;
	logic do_push;
	logic do_pop;

	// Push refused when full; pop refused when empty
	assign do_push = push_i && !full_o;
	assign do_pop  = pop_i && !empty_o;

	// Storage is not reset, only the pointers and the fill level are
	always_ff @(posedge clk_i)
	begin
		if (ce_i && do_push)
			mem_r[wr_r] <= data_i;
	end

	// Pointers and fill level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wr_r    <= '0;
			rd_r    <= '0;
			level_r <= '0;
		end
		else if (ce_i)
		begin
			if (do_push)
				wr_r <= wr_r + 1'b1;
			if (do_pop)
				rd_r <= rd_r + 1'b1;
			if (do_push && !do_pop)
				level_r <= level_r + 1'b1;
			else if (do_pop && !do_push)
				level_r <= level_r - 1'b1;
		end
	end

	assign head_o  = empty_o ? W'(`CODE_EMPTY) : mem_r[rd_r];
	assign empty_o = (level_r == '0);
	assign full_o  = (level_r == LW'(DEPTH));
	assign level_o = level_r;
endmodule

// >>> hdl/irq_queue_ctrl.sv
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "irq_queue_cfg.svh"

// Contract
// - Measurement epoch bit 6, antenna epoch bit 5
// - Pulse-per-second pending at bit 4
// - Clear register one: ones clear channels
// - Clear register two clears upper sources
// - Bits 3..0 clear channels 35..32
// - Queue read returns six-bit source code
// - Empty queue reads 63, upper bits zero
// - Low queue full sets low overflow
// - High queue full sets high overflow
// - Overflow flags cleared by writing one
// - Status bits 13..7 low fill level
// - Status bits 6..0 high fill level
// - Masked-off events only set pending
// - Priority bit selects low or high queue
// - DMA error bit 9, IQ detector bit 8
// - Queues empty at reset
module irq_queue_ctrl #(
	parameter int NSRC  = `NUM_SOURCES,
	parameter int DEPTH = `QUEUE_DEPTH
) (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	input  wire logic [NSRC-1:0]   event_i,
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic      [31:0]       dat_o,
	output logic                   ack_o,
	output logic                   irq_o
);
	localparam int LW = $clog2(DEPTH+1);

	// Elaboration guard: the register layout fixes source count and fill width
	if (NSRC != `NUM_SOURCES)
	begin : bad_nsrc
		$error("irq_queue_ctrl serves exactly 42 sources");
	end
	if (DEPTH != `QUEUE_DEPTH)
	begin : bad_depth
		$error("fill fields are seven bits wide, depth must be 64");
	end

	// ==========================================
	// Bus decode
	logic req;
	logic wr_stb;
	logic rd_stb;
	logic [31:0] wmask;

	assign req    = cyc_i && stb_i && !ack_o;
	assign wr_stb = req && we_i && ce_i;
	assign rd_stb = req && !we_i && ce_i;
	assign wmask  = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction

	// Map upper-register bits onto their sources in the 42-bit layout
	function automatic logic [NSRC-1:0] upper_map(input logic [31:0] v);
		logic [NSRC-1:0] r;
		r = '0;
		r[31:0]  = '0;
		r[35:32] = v[3:0];
		r[41:36] = v[`BIT_DMA_ERR:`BIT_PPS];
		return r;
	endfunction

	function automatic logic [31:0] upper_pack(input logic [NSRC-1:0] v);
		logic [31:0] r;
		r = `RESET_ZERO;
		r[3:0] = v[35:32];
		r[`BIT_DMA_ERR:`BIT_PPS] = v[41:36];
		return r;
	endfunction

	// ==========================================
	// Mask and priority registers
	logic [NSRC-1:0] mask_r;
	logic [NSRC-1:0] prio_r;

	// Software writes steer routing
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_r <= '0;
			prio_r <= '0;
		end
		else if (wr_stb)
		begin
			if (hit(adr_i, `OFS_MASK_LO))
				mask_r[31:0] <= (mask_r[31:0] & ~wmask) | (dat_i & wmask);
			if (hit(adr_i, `OFS_MASK_HI))
				mask_r <= (mask_r & ~upper_map(wmask)) | (upper_map(dat_i & wmask));
			if (hit(adr_i, `OFS_PRIO_LO))
				prio_r[31:0] <= (prio_r[31:0] & ~wmask) | (dat_i & wmask);
			if (hit(adr_i, `OFS_PRIO_HI))
				prio_r <= (prio_r & ~upper_map(wmask)) | (upper_map(dat_i & wmask));
		end
	end

	// ==========================================
	// Pending flags
	logic [NSRC-1:0] pend_r;
	logic [NSRC-1:0] clr;
	logic [31:0]     upper_snap_r;

	always_comb
	begin
		clr = '0;
		if (wr_stb && hit(adr_i, `OFS_CLEAR_LO))
			clr[31:0] = dat_i & wmask;
		if (wr_stb && hit(adr_i, `OFS_CLEAR_HI))
			clr = upper_map(dat_i & wmask);
	end

	// Set beats clear so a coincident event is kept
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pend_r <= '0;
		else if (ce_i)
			pend_r <= (pend_r & ~clr) | event_i;
	end

	// Upper flags are sampled when the lower word is read, so both reads agree
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			upper_snap_r <= `RESET_ZERO;
		else if (rd_stb && hit(adr_i, `OFS_PEND_LO))
			upper_snap_r <= upper_pack(pend_r);
	end

	// ==========================================
	// Queues
	logic [NSRC-1:0] fire;
	logic low_push;
	logic high_push;
	irq_queue_pkg::code_t low_code;
	irq_queue_pkg::code_t high_code;
	irq_queue_pkg::code_t low_head;
	irq_queue_pkg::code_t high_head;
	logic low_full;
	logic high_full;
	logic low_empty;
	logic high_empty;
	logic [LW-1:0] low_lvl;
	logic [LW-1:0] high_lvl;
	logic low_pop;
	logic high_pop;

	assign fire = event_i & mask_r;

	// Lowest source wins one slot per cycle per queue; others keep pending only
	always_comb
	begin
		low_push  = 1'b0;
		high_push = 1'b0;
		low_code  = `CODE_EMPTY;
		high_code = `CODE_EMPTY;
		for (int i = NSRC - 1; i >= 0; i--)
		begin
			if (fire[i] && !prio_r[i])
			begin
				low_push = 1'b1;
				low_code = i[`CODE_W-1:0];
			end
			if (fire[i] && prio_r[i])
			begin
				high_push = 1'b1;
				high_code = i[`CODE_W-1:0];
			end
		end
	end

	assign low_pop  = rd_stb && hit(adr_i, `OFS_QUEUE_LOW);
	assign high_pop = rd_stb && hit(adr_i, `OFS_QUEUE_HIGH);

	// Queue storage is not cleared at reset, but the level is, so no stale entry is read
	code_fifo #(.DEPTH(DEPTH), .W(`CODE_W)) low_q (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.push_i  (low_push),
		.data_i  (low_code),
		.pop_i   (low_pop),
		.head_o  (low_head),
		.full_o  (low_full),
		.empty_o (low_empty),
		.level_o (low_lvl)
	);

	code_fifo #(.DEPTH(DEPTH), .W(`CODE_W)) high_q (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ce_i    (ce_i),
		.push_i  (high_push),
		.data_i  (high_code),
		.pop_i   (high_pop),
		.head_o  (high_head),
		.full_o  (high_full),
		.empty_o (high_empty),
		.level_o (high_lvl)
	);

	// ==========================================
	// Overflow flags
	logic low_ovf_r;
	logic high_ovf_r;
	logic low_ovf_set;
	logic high_ovf_set;
	logic stat_wr;

	// A pop in the same cycle does not free a slot for the push
	assign low_ovf_set  = low_push && low_full;
	assign high_ovf_set = high_push && high_full;
	assign stat_wr      = wr_stb && hit(adr_i, `OFS_QUEUE_STAT) && sel_i[1];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			low_ovf_r  <= 1'b0;
			high_ovf_r <= 1'b0;
		end
		else if (ce_i)
		begin
			low_ovf_r  <= low_ovf_set | (low_ovf_r & ~(stat_wr & dat_i[`STAT_LOW_OVF]));
			high_ovf_r <= high_ovf_set | (high_ovf_r & ~(stat_wr & dat_i[`STAT_HIGH_OVF]));
		end
	end

	// ==========================================
	// Read data and acknowledge
	logic [31:0] rdata;

	always_comb
	begin
		rdata = `RESET_ZERO;
		unique case (1'b1)
			hit(adr_i, `OFS_MASK_LO):    rdata = mask_r[31:0];
			hit(adr_i, `OFS_MASK_HI):    rdata = upper_pack(mask_r);
			hit(adr_i, `OFS_PRIO_LO):    rdata = prio_r[31:0];
			hit(adr_i, `OFS_PRIO_HI):    rdata = upper_pack(prio_r);
			hit(adr_i, `OFS_PEND_LO):    rdata = pend_r[31:0];
			hit(adr_i, `OFS_PEND_HI):    rdata = upper_snap_r;
			hit(adr_i, `OFS_QUEUE_LOW):  rdata[`CODE_W-1:0] = low_head;
			hit(adr_i, `OFS_QUEUE_HIGH): rdata[`CODE_W-1:0] = high_head;
			hit(adr_i, `OFS_QUEUE_STAT):
			begin
				rdata[`STAT_LOW_OVF]  = low_ovf_r;
				rdata[`STAT_HIGH_OVF] = high_ovf_r;
				rdata[`STAT_LOW_LVL_HI:`STAT_LOW_LVL_LO]   = low_lvl;
				rdata[`STAT_HIGH_LVL_HI:`STAT_HIGH_LVL_LO] = high_lvl;
			end
			default:                     rdata = `RESET_ZERO;
		endcase
	end

	// One registered ack per request, a cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= `RESET_ZERO;
		end
		else if (ce_i)
		begin
			ack_o <= req;
			if (req && !we_i)
				dat_o <= rdata;
		end
	end

	// Interrupt line follows queue occupancy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_o <= 1'b0;
		else if (ce_i)
			irq_o <= !(low_empty && high_empty) || low_push || high_push;
	end

	// ==========================================
	// Checks
	overflow_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && low_push && low_full |=> low_ovf_r)
		else $error("low overflow not set");
	overflow_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && high_push && high_full |=> high_ovf_r)
		else $error("high overflow not set");
	ovf_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && stat_wr && dat_i[`STAT_LOW_OVF] && !low_ovf_set |=> !low_ovf_r)
		else $error("low overflow not cleared");
	pend_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && event_i[`NUM_SOURCES-1] |=> pend_r[`NUM_SOURCES-1])
		else $error("pending not set");
	pend_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && clr[0] && !event_i[0] |=> !pend_r[0])
		else $error("pending not cleared");
	empty_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && low_pop && low_empty |=> dat_o == 32'(`CODE_EMPTY))
		else $error("empty queue code wrong");
	fifo_pop_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && low_pop && !low_empty && !low_push |=> low_lvl == $past(low_lvl) - 1'b1)
		else $error("pop did not lower level");
	masked_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && fire[0] && prio_r[0] && !high_full |=> !high_empty)
		else $error("high priority event lost");
	irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && !low_empty ##1 ce_i |-> irq_o)
		else $error("irq dropped while queue holds data");

	// Steps of a queue read: a stored code is taken, then shown on the bus
	sequence low_read_s;
		ce_i && low_pop && !low_empty;
	endsequence

	sequence code_shown_s;
		dat_o == 32'($past(low_head));
	endsequence

	// The oldest code leaves the queue through the read data
	pop_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		low_read_s |=> code_shown_s)
		else $error("queue read returned wrong code");

	// Line falls once nothing is held or arriving
	irq_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && low_empty && high_empty && !low_push && !high_push |=> !irq_o)
		else $error("irq held with both queues empty");
endmodule

// >>> test/event_source_model.sv
`timescale 1ns/1ps

// ==========================================
// Event sources and interrupt sink of the core
module event_source_model (
	input  wire logic        clk_i,
	input  wire logic        irq_i,
	output logic      [41:0] event_o,
	output logic             irq_seen_o
);
	// Sources idle low until a burst is commanded
	initial event_o = 42'h0;
	initial irq_seen_o = 1'b0;

	// Level held n cycles: each cycle counts as one event
	task automatic pulse(input int idx, input int n);
		@(posedge clk_i);
		event_o <= 42'h1 << idx;
		repeat (n - 1) @(posedge clk_i);
		@(posedge clk_i);
		event_o <= 42'h0;
	endtask

	// Interrupt line latched as the system controller would see it
	always @(posedge clk_i)
	begin
		irq_seen_o <= irq_seen_o | irq_i;
	end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "irq_queue_cfg.svh"

// ==========================================
// Register-level bench for the interrupt queue unit
module tb_top;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_w;
	logic [31:0] dat_r;
	logic        ack;
	logic        irq;
	logic        seen;
	logic [41:0] ev;
	int          err_total;
	int          n_checks;
	int          cycles;
	logic        ovq;
	logic        ce;

	// Clock enable driven by the bench so the freeze path is exercised
	irq_queue_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .event_i(ev), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_o(irq));
	event_source_model src (.clk_i(clk_i), .irq_i(irq), .event_o(ev), .irq_seen_o(seen));

	// ==========================================
	// Clock, reset and hang guard
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			$display("CHECK FAILED %0t timeout", $time);
			err_total++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask

	// ==========================================
	// Classic single-cycle bus access, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_w <= d;
		sel <= 4'hF;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
			chk(32'hDEAD_0000, 32'h0000_0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	// ==========================================
	// Main sequence
	initial
	begin
		{cyc, stb, we, adr, sel, dat_w} = '0;
		ce = 1'b1;
		err_total = 0;
		n_checks = 0;
		rst_i = 1'b1;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		// Empty queues read the empty code, status all clear
		rd(`OFS_QUEUE_LOW, 32'h0000_003F);
		rd(`OFS_QUEUE_HIGH, 32'h0000_003F);
		rd(`OFS_QUEUE_STAT, 32'h0000_0000);
		// Masked-off upper sources: pending only, cleared by one
		for (int c = 32; c < 42; c++)
		begin
			src.pulse(c, 1);
			rd(`OFS_PEND_LO, 32'h0000_0000);
			rd(`OFS_PEND_HI, 32'h1 << (c - 32));
			wr(`OFS_CLEAR_HI, 32'hFFFF_FC00);
			rd(`OFS_PEND_LO, 32'h0000_0000);
			rd(`OFS_PEND_HI, 32'h1 << (c - 32));
			wr(`OFS_CLEAR_HI, 32'h1 << (c - 32));
			rd(`OFS_PEND_LO, 32'h0000_0000);
			rd(`OFS_PEND_HI, 32'h0000_0000);
		end
		rd(`OFS_QUEUE_LOW, 32'h0000_003F);
		chk({31'h0, seen}, 32'h0000_0000);
		// Channel clear: ones clear, zeros keep
		src.pulse(0, 1);
		src.pulse(31, 1);
		rd(`OFS_PEND_LO, 32'h8000_0001);
		wr(`OFS_CLEAR_LO, 32'h0000_0001);
		rd(`OFS_PEND_LO, 32'h8000_0000);
		wr(`OFS_CLEAR_LO, 32'h8000_0000);
		rd(`OFS_PEND_LO, 32'h0000_0000);
		// Every source queued in order, low queue
		wr(`OFS_MASK_LO, 32'hFFFF_FFFF);
		wr(`OFS_MASK_HI, 32'h0000_03FF);
		for (int c = 0; c < 42; c++)
			src.pulse(c, 1);
		rd(`OFS_QUEUE_STAT, 32'd42 << 7);
		chk({31'h0, irq}, 32'h0000_0001);
		for (int c = 0; c < 42; c++)
			rd(`OFS_QUEUE_LOW, c);
		rd(`OFS_QUEUE_LOW, 32'h0000_003F);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0000_0000);
		// Priority bit steers antenna epoch to the high queue
		wr(`OFS_PRIO_HI, 32'h0000_0020);
		src.pulse(37, 1);
		rd(`OFS_QUEUE_STAT, 32'h0000_0001);
		rd(`OFS_QUEUE_LOW, 32'h0000_003F);
		rd(`OFS_QUEUE_HIGH, 32'd37);
		// Overrun of each queue, write-one clear, drain
		for (int q = 0; q < 2; q++)
		begin
			ovq = q[0];
			wr(`OFS_PRIO_LO, {31'h0, ovq});
			src.pulse(0, 65);
			rd(`OFS_QUEUE_STAT, ovq ? 32'h0000_4040 : 32'h0000_A000);
			wr(`OFS_QUEUE_STAT, 32'h0000_0000);
			rd(`OFS_QUEUE_STAT, ovq ? 32'h0000_4040 : 32'h0000_A000);
			wr(`OFS_QUEUE_STAT, ovq ? 32'h0000_4000 : 32'h0000_8000);
			rd(`OFS_QUEUE_STAT, ovq ? 32'h0000_0040 : 32'h0000_2000);
			repeat (64) rd(ovq ? `OFS_QUEUE_HIGH : `OFS_QUEUE_LOW, 32'h0000_0000);
			rd(ovq ? `OFS_QUEUE_HIGH : `OFS_QUEUE_LOW, 32'h0000_003F);
		end
		// Frozen core ignores an enabled event: no pending bit, no queue entry
		wr(`OFS_CLEAR_LO, 32'hFFFF_FFFF);
		@(posedge clk_i);
		ce <= 1'b0;
		src.pulse(5, 2);
		@(posedge clk_i);
		ce <= 1'b1;
		rd(`OFS_PEND_LO, 32'h0000_0000);
		rd(`OFS_QUEUE_STAT, 32'h0000_0000);
		final_report();
	end
endmodule
